// File: design/fsa_pkg.sv
// Purpose: Shared constants and carriers for the fault status block.
// Assumes: Eight-bit register read port, one clock.
// Notes:   Offsets and reset values of both status registers.
package fsa_pkg;

    localparam logic [7:0] ADDR_STATUS_SECOND = 8'h42;
    localparam logic [7:0] ADDR_STATUS_THIRD  = 8'h43;
    localparam logic [7:0] RESET_STATUS       = 8'h00;

    // Field positions in the second status register.
    localparam int POS_RAIL_12V  = 0;
    localparam int POS_SUMMARY_S = 1;
    localparam int POS_FAN_ONE   = 2;
    localparam int POS_FAN_FOUR  = 5;
    localparam int POS_DIODE_ONE = 6;
    localparam int POS_DIODE_TWO = 7;

    // Field positions in the third status register.
    localparam int POS_CPU_LIMIT = 0;
    localparam int POS_CPU_DATA  = 1;
    localparam int POS_LINK_ERR  = 2;
    localparam int POS_OVERTEMP  = 3;
    localparam int POS_SUMMARY_T = 7;

    // Raw conditions sampled from the monitoring engines.
    typedef struct packed {
        logic       rail_12v_out_of_limit;
        logic [3:0] fan_below_min;
        logic [2:0] fan_drive_on;
        logic       fourth_tach_input;
        logic       timer_exceeded;
        logic       diode_one_fault;
        logic       diode_two_fault;
        logic       cpu_client_limit;
        logic       cpu_data_error;
        logic       link_error_a;
        logic       overtemp_active;
        logic       fourth_reg_any;
    } fsa_cause_type;

endpackage : fsa_pkg

// File: design/fsa_sticky_bit.sv
// Purpose: One latched status bit with a conditional clear on read.
// Assumes: Cause and read strobe are on the same clock.
// Notes:   A set in the clearing cycle wins.
`timescale 1ns/1ps
`default_nettype none
module fsa_sticky_bit (
    input  wire logic clock_in,
    input  wire logic srst_in,
    input  wire logic set_in,
    input  wire logic hold_in,
    input  wire logic read_in,
    output logic      flag_out
);
    logic flag_d;

    // Clear only when read and the cause has gone.
    assign flag_d = set_in | (flag_out & ~(read_in & ~hold_in));

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            flag_out <= 1'b0;
        end else begin
            flag_out <= flag_d;
        end
    end
endmodule : fsa_sticky_bit
`default_nettype wire

// File: design/fsa_status.sv
// Purpose: Second and third event status registers with chain summaries.
// Assumes: Limit comparison, fan measurement and link engines are outside.
// Notes:   Register reads are a one-cycle strobe with an address.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 12 V bit sticky, read clears once gone.
// - Second bit 1 ORs third register bits.
// - Third bit 7 ORs fourth register bits.
// - Fans one-three fail, suppressed while drive off.
// - Tach mode: fan four, suppressed by drive three.
// - Timer mode: set when time exceeds limit.
// - Bit 6 flags diode one fault.
// - Bit 7 flags diode two fault.
// - CPU limit bit sticky, read clears once gone.
// - Bit 1 flags invalid processor thermal data.
// - Bit 2 flags thermal link communication error.
// - Overtemp clears on read below hysteresis point.
// - Both registers reset 0x00, read-only.
// - High above limit, low at or below.
module fsa_status (
    input  wire logic                  clock_in,
    input  wire logic                  srst_in,
    input  wire fsa_pkg::fsa_cause_type cause_in,
    input  wire logic                  read_strobe_in,
    input  wire logic [7:0]            read_addr_in,
    input  wire logic                  write_strobe_in,
    input  wire logic [7:0]            write_addr_in,
    input  wire logic [7:0]            write_data_in,
    output logic [7:0]                 read_data_out,
    output logic [7:0]                 status_second_out,
    output logic [7:0]                 status_third_out
);
    ////////////////////////////////////////////////////////////////////////
    // Address decoding, shared by the read and write sides.
    function automatic logic [1:0] fsa_select(input logic [7:0] addr);
        logic [1:0] sel;
        sel = 2'b00;
        if (addr == fsa_pkg::ADDR_STATUS_SECOND) begin
            sel = 2'b01;
        end else if (addr == fsa_pkg::ADDR_STATUS_THIRD) begin
            sel = 2'b10;
        end
        return sel;
    endfunction : fsa_select

    wire logic [1:0] read_select;
    wire logic [1:0] write_select;
    wire logic       read_second;
    wire logic       read_third;
    wire logic       write_ignored;

    assign read_select  = fsa_select(read_addr_in);
    assign write_select = fsa_select(write_addr_in);
    assign read_second  = read_strobe_in & read_select[0];
    assign read_third   = read_strobe_in & read_select[1];

    // A host write to either register changes nothing: every bit is
    // owned by hardware.
    assign write_ignored = write_strobe_in & (|write_select)
        & (|write_data_in);

    ////////////////////////////////////////////////////////////////////////
    // Fan drive enables; fan four shares drive three.
    wire logic fan_drive_one;
    wire logic fan_drive_two;
    wire logic fan_drive_three;

    assign fan_drive_one   = cause_in.fan_drive_on[0];
    assign fan_drive_two   = cause_in.fan_drive_on[1];
    assign fan_drive_three = cause_in.fan_drive_on[2];

    ////////////////////////////////////////////////////////////////////////
    // Events; readings arrive already compared against their limits.
    wire logic rail_event;
    wire logic fan_one_event;
    wire logic fan_two_event;
    wire logic fan_three_event;
    wire logic fan_four_event;
    wire logic shared_event;
    wire logic diode_one_event;
    wire logic diode_two_event;
    wire logic cpu_limit_event;
    wire logic cpu_data_event;
    wire logic link_event;
    wire logic overtemp_event;

    assign rail_event = cause_in.rail_12v_out_of_limit;

    // A slow fan is not flagged while its drive is off.
    assign fan_one_event = cause_in.fan_below_min[0]
        & fan_drive_one;
    assign fan_two_event = cause_in.fan_below_min[1]
        & fan_drive_two;
    assign fan_three_event = cause_in.fan_below_min[2]
        & fan_drive_three;
    assign fan_four_event = cause_in.fan_below_min[3]
        & fan_drive_three;

    // The shared pin picks fan four or the thermal timer for bit 5.
    assign shared_event = cause_in.fourth_tach_input
        ? fan_four_event : cause_in.timer_exceeded;

    assign diode_one_event = cause_in.diode_one_fault;
    assign diode_two_event = cause_in.diode_two_fault;
    assign cpu_limit_event = cause_in.cpu_client_limit;
    assign cpu_data_event  = cause_in.cpu_data_error;
    assign link_event      = cause_in.link_error_a;
    assign overtemp_event  = cause_in.overtemp_active;

    ////////////////////////////////////////////////////////////////////////
    // Sticky bits. The cause level is also the hold term, so a read
    // cannot clear a bit whose cause still stands.
    wire logic [7:0] s_set;
    wire logic [7:0] s_hold;
    wire logic [3:0] t_set;
    wire logic [3:0] t_hold;
    wire logic [7:0] second_bits;
    wire logic [3:0] third_bits;

    assign s_set = {diode_two_event,
                    diode_one_event,
                    shared_event,
                    fan_three_event,
                    fan_two_event,
                    fan_one_event,
                    1'b0,
                    rail_event};
    assign t_set = {overtemp_event,
                    link_event,
                    cpu_data_event,
                    cpu_limit_event};
    assign s_hold = s_set;
    assign t_hold = t_set;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_second
            if (gi == fsa_pkg::POS_SUMMARY_S) begin : g_sum
                assign second_bits[gi] = 1'b0;
            end else begin : g_bit
                fsa_sticky_bit u_bit (
                    .clock_in (clock_in),
                    .srst_in  (srst_in),
                    .set_in   (s_set[gi]),
                    .hold_in  (s_hold[gi]),
                    .read_in  (read_second),
                    .flag_out (second_bits[gi])
                );
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_third
            fsa_sticky_bit u_bit (
                .clock_in (clock_in),
                .srst_in  (srst_in),
                .set_in   (t_set[gi]),
                .hold_in  (t_hold[gi]),
                .read_in  (read_third),
                .flag_out (third_bits[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Named fields of both registers.
    wire logic rail_12v_flag;
    wire logic chain_summary_flag;
    wire logic fan_one_fail;
    wire logic fan_two_fail;
    wire logic fan_three_fail;
    wire logic fan_four_or_timer_flag;
    wire logic diode_one_fault;
    wire logic diode_two_fault;
    wire logic cpu_client_limit_flag;
    wire logic cpu_data_flag;
    wire logic link_error_a;
    wire logic overtemp_flag;
    wire logic chain_summary_flag_upper;

    assign rail_12v_flag          = second_bits[fsa_pkg::POS_RAIL_12V];
    assign fan_one_fail           = second_bits[fsa_pkg::POS_FAN_ONE];
    assign fan_two_fail           = second_bits[fsa_pkg::POS_FAN_ONE + 1];
    assign fan_three_fail         = second_bits[fsa_pkg::POS_FAN_ONE + 2];
    assign fan_four_or_timer_flag = second_bits[fsa_pkg::POS_FAN_FOUR];
    assign diode_one_fault        = second_bits[fsa_pkg::POS_DIODE_ONE];
    assign diode_two_fault        = second_bits[fsa_pkg::POS_DIODE_TWO];
    assign cpu_client_limit_flag  = third_bits[fsa_pkg::POS_CPU_LIMIT];
    assign cpu_data_flag          = third_bits[fsa_pkg::POS_CPU_DATA];
    assign link_error_a           = third_bits[fsa_pkg::POS_LINK_ERR];
    assign overtemp_flag          = third_bits[fsa_pkg::POS_OVERTEMP];

    // Bit 7 of the third register is the fourth register's summary, and
    // bit 1 of the second register covers every bit of the third.
    assign chain_summary_flag_upper = cause_in.fourth_reg_any;
    assign chain_summary_flag = (|third_bits)
        | chain_summary_flag_upper;

    ////////////////////////////////////////////////////////////////////////
    // Register views and the read mux; reserved bits read as zero.
    wire logic [7:0] second_view;
    wire logic [7:0] third_view;
    wire logic [7:0] read_data_d;

    assign third_view = {chain_summary_flag_upper,
                         3'h0,
                         overtemp_flag,
                         link_error_a,
                         cpu_data_flag,
                         cpu_client_limit_flag};
    assign second_view = {diode_two_fault,
                          diode_one_fault,
                          fan_four_or_timer_flag,
                          fan_three_fail,
                          fan_two_fail,
                          fan_one_fail,
                          chain_summary_flag,
                          rail_12v_flag};

    // Unmapped addresses read as zero.
    assign read_data_d = read_select[0] ? second_view
        : (read_select[1] ? third_view : 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // Output registers; every output leaves from a flip-flop.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            read_data_out <= fsa_pkg::RESET_STATUS;
        end else begin
            read_data_out <= read_data_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            status_second_out <= fsa_pkg::RESET_STATUS;
            status_third_out  <= fsa_pkg::RESET_STATUS;
        end else begin
            status_second_out <= second_view;
            status_third_out  <= third_view;
        end
    end
endmodule : fsa_status
`default_nettype wire

// File: verif/fsa_status_monitor.sv
// Purpose: Bound checker for the fault status registers.
// Assumes: A sticky cause shows on the outputs two edges after it is sampled.
// Notes:   Sees only the top ports.
`timescale 1ns/1ps
`default_nettype none
module fsa_status_monitor (
    input wire logic                   clock_in,
    input wire logic                   srst_in,
    input wire fsa_pkg::fsa_cause_type cause_in,
    input wire logic                   read_strobe_in,
    input wire logic [7:0]             read_addr_in,
    input wire logic                   write_strobe_in,
    input wire logic [7:0]             write_addr_in,
    input wire logic [7:0]             write_data_in,
    input wire logic [7:0]             read_data_out,
    input wire logic [7:0]             status_second_out,
    input wire logic [7:0]             status_third_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    wire logic shared_set = cause_in.fourth_tach_input ?
        cause_in.fan_below_min[3] && cause_in.fan_drive_on[2] :
        cause_in.timer_exceeded;
    sequence s_read(a, gone);
        read_strobe_in && read_addr_in == a && gone ##1 1'b1;
    endsequence
    a_third_reserved_zero: assert property (
        status_third_out[6:4] == 3'h0) else $error("reserved bits set");
    a_chain_summary_or: assert property (
        status_second_out[1] == |status_third_out) else $error("summary");
    a_read_third_view: assert property (
        read_addr_in == 8'h43 |=> read_data_out == status_third_out)
        else $error("read data");
    a_rail_read_clear: assert property (
        s_read(8'h42, !cause_in.rail_12v_out_of_limit)
        |=> !status_second_out[0]) else $error("rail bit kept");
    a_overtemp_read_clear: assert property (
        s_read(8'h43, !cause_in.overtemp_active)
        |=> !status_third_out[3]) else $error("overtemp bit kept");
    a_fan_drive_gate: assert property ($rose(status_second_out[2]) |->
        $past(cause_in.fan_below_min[0] && cause_in.fan_drive_on[0], 2))
        else $error("fan bit without cause");
    a_diode_fault_set: assert property (
        cause_in.diode_one_fault ##1 1'b1 |=> status_second_out[6])
        else $error("diode bit missed");
    a_link_error_set: assert property (
        cause_in.link_error_a ##1 1'b1 |=> status_third_out[2])
        else $error("link bit missed");
    a_shared_pin_mode: assert property (
        shared_set ##1 1'b1 |=> status_second_out[5])
        else $error("shared pin bit missed");
endmodule : fsa_status_monitor
bind fsa_status fsa_status_monitor mon (.clock_in(clock_in),
    .srst_in(srst_in), .cause_in(cause_in), .read_strobe_in(read_strobe_in),
    .read_addr_in(read_addr_in), .write_strobe_in(write_strobe_in),
    .write_addr_in(write_addr_in), .write_data_in(write_data_in),
    .read_data_out(read_data_out), .status_second_out(status_second_out),
    .status_third_out(status_third_out));
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Random and directed bench for the fault status registers.
// Assumes: Outputs are settled at the falling edge.
// Notes:   A shadow model predicts every output each cycle.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock_in = 1'b0, srst_in = 1'b1, rs = 1'b0, ws = 1'b0, chk = 1'b0;
    fsa_pkg::fsa_cause_type cause_in = '0;
    logic [7:0] ra = 8'h00, wa = 8'h00, wd = 8'h00;
    logic [7:0] b2_q, b3_q, e2_q, e3_q, ed_q;
    wire logic [7:0] rdo, s2o, s3o, v2, v3;
    integer seed = 32'h1aa0aa0e, bad_count = 0, tests_run = 0;
    fsa_status uut (.clock_in(clock_in), .srst_in(srst_in), .cause_in(cause_in),
        .read_strobe_in(rs), .read_addr_in(ra), .write_strobe_in(ws),
        .write_addr_in(wa), .write_data_in(wd), .read_data_out(rdo),
        .status_second_out(s2o), .status_third_out(s3o));
    always #25 clock_in = ~clock_in;
    function automatic logic [7:0] nx2(input fsa_pkg::fsa_cause_type c);
        return {c.diode_two_fault, c.diode_one_fault, c.fourth_tach_input ?
            c.fan_below_min[3] & c.fan_drive_on[2] : c.timer_exceeded,
            c.fan_below_min[2:0] & c.fan_drive_on, 1'b0,
            c.rail_12v_out_of_limit};
    endfunction : nx2
    assign v3 = {cause_in.fourth_reg_any, b3_q[6:0]};
    assign v2 = {b2_q[7:2], |v3, b2_q[0]};
    always @(posedge clock_in) begin
        if (srst_in) {b2_q, b3_q, e2_q, e3_q, ed_q} <= '0;
        else begin
            b2_q <= nx2(cause_in) | (rs && ra == 8'h42 ? 8'h00 : b2_q);
            b3_q <= {4'h0, cause_in.overtemp_active, cause_in.link_error_a,
                cause_in.cpu_data_error, cause_in.cpu_client_limit}
                | (rs && ra == 8'h43 ? 8'h00 : b3_q);
            e2_q <= v2;
            e3_q <= v3;
            ed_q <= ra == 8'h42 ? v2 : (ra == 8'h43 ? v3 : 8'h00);
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask : check
    always @(negedge clock_in) if (chk) begin
        check(s2o, e2_q);
        check(s3o, e3_q);
        check(rdo, ed_q);
    end
    task automatic step(input logic [16:0] c, input logic [7:0] a);
        @(posedge clock_in);
        cause_in <= fsa_pkg::fsa_cause_type'(c);
        rs <= a != 8'h00;
        ra <= a;
        ws <= 1'($random(seed));
        wa <= a;
        wd <= 8'($random(seed));
    endtask : step
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5000) @(posedge clock_in);
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clock_in);
        srst_in <= 1'b0;
        chk = 1'b1;
        // Every cause but fourth_reg_any held through reads, then all gone while reading.
        for (int i = 0; i < 8; i++) begin
            step(i < 4 ? 17'h1fffe : 17'h0, 8'h42 + 8'(i & 1));
        end
        $display("test corner done");
        for (int seg = 0; seg < 4; seg++) begin
            chk = 1'b0;
            srst_in <= seg == 2;
            repeat (3) step(17'(seg & 1), 8'h00);
            srst_in <= 1'b0;
            chk = 1'b1;
            repeat (300) step(17'($random(seed) & $random(seed)) & 17'h1fffe
                | 17'(seg & 1), ($random(seed) & 1) ? 8'h42 + 8'($random(seed) & 3)
                : 8'h00);
            $display("test %0d done", seg);
        end
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
